// [rtl/metering_pkg.sv]
package metering_pkg;

    // ------------------------------------------------------------------
    // Register indices and byte addresses (byte address = 4 * index)
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W          = 18;
    localparam logic [15:0] IDX_PEAK        = 16'he501;
    localparam logic [15:0] IDX_STATUS      = 16'he502;
    localparam logic [15:0] IDX_SIGN        = 16'he617;
    localparam logic [15:0] IDX_ACCUMULATION_MODE_REG     = 16'he701;
    localparam logic [15:0] IDX_PULSE_MODE  = 16'he900;
    localparam logic [15:0] IDX_HALF_CYC    = 16'he901;
    localparam logic [15:0] IDX_LINE_CTRL   = 16'he902;
    localparam logic [15:0] IDX_PHASE_CAL   = 16'he903;
    localparam logic [15:0] IDX_POWER_SMP   = 16'he904;

    localparam logic [17:0] ADDR_PEAK       = {IDX_PEAK, 2'b00};
    localparam logic [17:0] ADDR_STATUS     = {IDX_STATUS, 2'b00};
    localparam logic [17:0] ADDR_SIGN       = {IDX_SIGN, 2'b00};
    localparam logic [17:0] ADDR_ACCUMULATION_MODE_REG    = {IDX_ACCUMULATION_MODE_REG, 2'b00};
    localparam logic [17:0] ADDR_PULSE_MODE = {IDX_PULSE_MODE, 2'b00};
    localparam logic [17:0] ADDR_HALF_CYC   = {IDX_HALF_CYC, 2'b00};
    localparam logic [17:0] ADDR_LINE_CTRL  = {IDX_LINE_CTRL, 2'b00};
    localparam logic [17:0] ADDR_PHASE_CAL  = {IDX_PHASE_CAL, 2'b00};
    localparam logic [17:0] ADDR_POWER_SMP  = {IDX_POWER_SMP, 2'b00};

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int unsigned ST_TOT_ACT      = 0;
    localparam int unsigned ST_FUND_ACT     = 1;
    localparam int unsigned ST_TOT_REACT    = 2;
    localparam int unsigned ST_FUND_REACT   = 3;
    localparam int unsigned ST_APPARENT     = 4;
    localparam int unsigned ST_LINE_DONE    = 5;
    localparam int unsigned ST_ACT_SIGN     = 6;   // 6..8
    localparam int unsigned ST_SUM1_SIGN    = 9;
    localparam int unsigned ST_REACT_SIGN   = 10;  // 10..12
    localparam int unsigned ST_SUM2_SIGN    = 13;
    localparam int unsigned ST_PULSE        = 14;  // 14..16
    localparam int unsigned ST_DSP_DONE     = 17;
    localparam int unsigned ST_SUM3_SIGN    = 18;
    localparam int unsigned ST_WIDTH        = 19;
    localparam int unsigned SG_ACT          = 0;   // 0..2
    localparam int unsigned SG_SUM1         = 3;
    localparam int unsigned SG_REACT        = 4;   // 4..6
    localparam int unsigned SG_SUM2         = 7;
    localparam int unsigned SG_SUM3         = 8;
    localparam int unsigned ACC_ACT_SEL     = 6;
    localparam int unsigned ACC_REACT_SEL   = 7;
    localparam int unsigned PM_DIS          = 9;   // 9..11
    localparam int unsigned PEAK_PHASE      = 24;  // 24..26

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0]  RST_ACCUMULATION_MODE_REG     = 8'h00;
    localparam logic [11:0] RST_PULSE_MODE  = 12'h000;
    localparam logic [15:0] RST_HALF_CYC    = 16'hffff;
    localparam logic [9:0]  RST_PHASE_CAL   = 10'h000;

    // ------------------------------------------------------------------
    // Transfer formats of narrow registers
    // ------------------------------------------------------------------
    function automatic logic [31:0] zero_pad24(input logic [23:0] v);
        return {8'h00, v};
    endfunction

    function automatic logic [31:0] zero_pad20(input logic [19:0] v);
        return {12'h000, v};
    endfunction

    function automatic logic [31:0] sign_ext24(input logic [23:0] v);
        return {{8{v[23]}}, v};
    endfunction

    function automatic logic [15:0] zero_pad10(input logic [9:0] v);
        return {6'h00, v};
    endfunction

endpackage

// [rtl/metering_event_status.sv]
`timescale 1ns/1ps
// Contract
// - Peak register low 24 bits hold the voltage channel peak magnitude.
// - Bits 24..26 mark phase A, B or C as source of the peak.
// - Peak register bits 31..27 always read zero.
// - Status bit 0 sets on bit-30 change of any total active accumulator.
// - Bit 1 flags fundamental active bit-30 change; zero when absent.
// - Status bit 2 sets on bit-30 change of any total reactive accumulator.
// - Bit 3 flags fundamental reactive bit-30 change; zero when absent.
// - Status bit 4 sets on bit-30 change of any apparent accumulator.
// - Line-cycle mode sets status bit 5 after programmed half cycles.
// - Bits 6..8 flag active sign change; mode bit 6 picks; sign 0..2.
// - Bit 9 flags first path sum sign change; sign in sign bit 3.
// - Bits 10..12 flag reactive sign change; mode bit 7 picks; sign 4..6.
// - Bit 13 flags second path sum sign change; sign in sign bit 7.
// - Bit 18 flags third path sum sign change; sign in sign bit 8.
// - Bits 14..16 set on falling edge of the three raw pulse levels.
// - Pulse flags still set while the matching output pin is disabled.
// - Pulse-mode fields 2:0, 5:3, 8:6 select each output's power type.
// - Status bit 17 sets when each 8 kHz processing cycle finishes.
// - Status bits 31..19 always read zero.
// - 24/20-bit zero-padded registers read as 32 bits, upper bits zero.
// - 24-bit signed sign-extended registers read with sign copied upward.
// - 10-bit registers read as 16 bits with six upper bits zero.
module metering_event_status
    import metering_pkg::*;
#(
    parameter bit HAS_FUND = 1'b1               // Fundamental measurement present
) (
    input  wire logic        pclk,              // Bus and core clock
    input  wire logic        presetn,           // Async reset, active low
    input  wire logic        psel,              // APB select
    input  wire logic        penable,           // APB access phase
    input  wire logic        pwrite,            // APB write
    input  wire logic [17:0] paddr,             // APB byte address
    input  wire logic [31:0] pwdata,            // APB write data
    output logic      [31:0] prdata,            // APB read data
    output logic             pready,            // APB ready
    output logic             pslverr,           // APB error, unmapped addr
    input  wire logic [2:0]  tot_active_bit30,  // Bit 30, phases A..C
    input  wire logic [2:0]  fund_active_bit30, // Bit 30, phases A..C
    input  wire logic [2:0]  tot_react_bit30,   // Bit 30, phases A..C
    input  wire logic [2:0]  fund_react_bit30,  // Bit 30, phases A..C
    input  wire logic [2:0]  apparent_bit30,    // Bit 30, phases A..C
    input  wire logic        half_cycle_tick,   // One pulse per half cycle
    input  wire logic [2:0]  tot_active_neg,    // Sign, 1 = negative
    input  wire logic [2:0]  fund_active_neg,   // Sign, 1 = negative
    input  wire logic [2:0]  tot_react_neg,     // Sign, 1 = negative
    input  wire logic [2:0]  fund_react_neg,    // Sign, 1 = negative
    input  wire logic [2:0]  path_sum_neg,      // Sum sign, paths 1..3
    input  wire logic [2:0]  pulse_level,       // Raw pulse levels 1..3
    input  wire logic        dsp_cycle_done,    // Processing cycle done
    input  wire logic        peak_valid,        // New peak available
    input  wire logic [23:0] peak_value,        // Peak magnitude
    input  wire logic [2:0]  peak_phase,        // Phase that made the peak
    input  wire logic [23:0] power_sample,      // Signed power sample
    output logic             pulse_out_first,   // Pulse pin 1, active low
    output logic             pulse_out_second,  // Pulse pin 2, active low
    output logic             pulse_out_third,   // Pulse pin 3, active low
    output logic      [8:0]  pulse_power_select,// Power type, 3 x 3 bits
    output logic      [9:0]  phase_cal          // Phase calibration value
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [ST_WIDTH-1:0] status;
        logic [23:0]         peak_mag;
        logic [2:0]          peak_src;
        logic [8:0]          signs;
        logic [7:0]          accumulation_mode_reg;
        logic [11:0]         pulse_mode;
        logic [15:0]         half_cyc;
        logic                line_en;
        logic [15:0]         half_cnt;
        logic [9:0]          phase_cal;
        logic [23:0]         power_smp;
        logic [2:0]          prev_ta;
        logic [2:0]          prev_fa;
        logic [2:0]          prev_tr;
        logic [2:0]          prev_fr;
        logic [2:0]          prev_va;
        logic [2:0]          prev_pulse;
        logic                primed;
        logic [2:0]          pins;
        logic [31:0]         rdata;
        logic                ready;
        logic                err;
    } state_t;

    state_t cur_ff;
    state_t nxt_cur;

    // ------------------------------------------------------------------
    // Source selection and bus decode
    // ------------------------------------------------------------------
    logic [2:0]          act_sign;
    logic [2:0]          react_sign;
    logic [8:0]          new_signs;
    logic [ST_WIDTH-1:0] set_vec;
    logic                acc_phase;
    logic                bus_done;
    logic                wr_done;
    logic                mapped;
    logic [31:0]         rd_mux;

    // Without fundamental measurement the total sources are the only ones
    always_comb begin
        if (HAS_FUND && cur_ff.accumulation_mode_reg[ACC_ACT_SEL]) begin
            act_sign = fund_active_neg;
        end else begin
            act_sign = tot_active_neg;
        end
        if (HAS_FUND && cur_ff.accumulation_mode_reg[ACC_REACT_SEL]) begin
            react_sign = fund_react_neg;
        end else begin
            react_sign = tot_react_neg;
        end
        new_signs = {path_sum_neg[2], path_sum_neg[1], react_sign,
                     path_sum_neg[0], act_sign};
    end

    // One wait state: pready rises in the second access cycle
    assign acc_phase = psel && penable;
    assign bus_done  = acc_phase && cur_ff.ready;
    assign wr_done   = bus_done && pwrite && !cur_ff.err;

    // Read mux with every narrow register formatted for transfer
    always_comb begin
        mapped = 1'b1;
        rd_mux = 32'h0000_0000;
        unique case (paddr)
            ADDR_PEAK: begin
                rd_mux = {5'h00, cur_ff.peak_src,
                          cur_ff.peak_mag};
            end
            ADDR_STATUS: begin
                rd_mux = {13'h0000, cur_ff.status};
            end
            ADDR_SIGN: begin
                rd_mux = {16'h0000, 7'h00, cur_ff.signs};
            end
            ADDR_ACCUMULATION_MODE_REG: begin
                rd_mux = {24'h00_0000, cur_ff.accumulation_mode_reg};
            end
            ADDR_PULSE_MODE: begin
                rd_mux = zero_pad20({8'h00, cur_ff.pulse_mode});
            end
            ADDR_HALF_CYC: begin
                rd_mux = {16'h0000, cur_ff.half_cyc};
            end
            ADDR_LINE_CTRL: begin
                rd_mux = {31'h0000_0000, cur_ff.line_en};
            end
            ADDR_PHASE_CAL: begin
                rd_mux = {16'h0000, zero_pad10(cur_ff.phase_cal)};
            end
            ADDR_POWER_SMP: begin
                rd_mux = sign_ext24(cur_ff.power_smp);
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Event detection
    // ------------------------------------------------------------------
    // Edges are only trusted once the history registers hold real levels,
    // otherwise the first cycle after reset would raise false flags.
    always_comb begin
        set_vec = '0;
        if (cur_ff.primed) begin
            set_vec[ST_TOT_ACT] =
                |(tot_active_bit30 ^ cur_ff.prev_ta);
            set_vec[ST_FUND_ACT]  = HAS_FUND &&
                |(fund_active_bit30 ^ cur_ff.prev_fa);
            set_vec[ST_TOT_REACT] =
                |(tot_react_bit30 ^ cur_ff.prev_tr);
            set_vec[ST_FUND_REACT] = HAS_FUND &&
                |(fund_react_bit30 ^ cur_ff.prev_fr);
            set_vec[ST_APPARENT] =
                |(apparent_bit30 ^ cur_ff.prev_va);
            set_vec[ST_ACT_SIGN+:3] =
                new_signs[SG_ACT+:3] ^ cur_ff.signs[SG_ACT+:3];
            set_vec[ST_SUM1_SIGN] =
                new_signs[SG_SUM1] ^ cur_ff.signs[SG_SUM1];
            set_vec[ST_REACT_SIGN+:3] =
                new_signs[SG_REACT+:3] ^ cur_ff.signs[SG_REACT+:3];
            set_vec[ST_SUM2_SIGN] =
                new_signs[SG_SUM2] ^ cur_ff.signs[SG_SUM2];
            set_vec[ST_SUM3_SIGN] =
                new_signs[SG_SUM3] ^ cur_ff.signs[SG_SUM3];
            // Raw levels, before the disable gate, so disabled pins still flag
            set_vec[ST_PULSE+:3] =
                cur_ff.prev_pulse & ~pulse_level;
        end
        set_vec[ST_DSP_DONE] = dsp_cycle_done;
        set_vec[ST_LINE_DONE] = cur_ff.line_en && half_cycle_tick &&
            (cur_ff.half_cnt + 16'h0001 >= cur_ff.half_cyc);
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        nxt_cur = cur_ff;

        // History of the watched levels
        nxt_cur.prev_ta    = tot_active_bit30;
        nxt_cur.prev_fa    = fund_active_bit30;
        nxt_cur.prev_tr    = tot_react_bit30;
        nxt_cur.prev_fr    = fund_react_bit30;
        nxt_cur.prev_va    = apparent_bit30;
        nxt_cur.prev_pulse = pulse_level;
        nxt_cur.primed     = 1'b1;
        nxt_cur.signs      = new_signs;

        // Sticky flags; a set in the clearing cycle wins
        if (wr_done && paddr == ADDR_STATUS) begin
            nxt_cur.status = (cur_ff.status &
                              ~pwdata[ST_WIDTH-1:0]) | set_vec;
        end else begin
            nxt_cur.status = cur_ff.status | set_vec;
        end

        // Peak capture keeps magnitude and source phase together
        if (peak_valid) begin
            nxt_cur.peak_mag = peak_value;
            nxt_cur.peak_src = peak_phase;
        end

        // Signed sample latched once per processing cycle
        if (dsp_cycle_done) begin
            nxt_cur.power_smp = power_sample;
        end

        // Half cycle counter restarts at each completed integration
        if (!cur_ff.line_en) begin
            nxt_cur.half_cnt = 16'h0000;
        end else if (half_cycle_tick) begin
            if (set_vec[ST_LINE_DONE]) begin
                nxt_cur.half_cnt = 16'h0000;
            end else begin
                nxt_cur.half_cnt = cur_ff.half_cnt + 16'h0001;
            end
        end

        // Pins idle high when disabled; the flag path above is untouched
        nxt_cur.pins = pulse_level | cur_ff.pulse_mode[PM_DIS+:3];

        // Software writable configuration
        if (wr_done) begin
            unique case (paddr)
                ADDR_ACCUMULATION_MODE_REG: begin
                    nxt_cur.accumulation_mode_reg = pwdata[7:0];
                end
                ADDR_PULSE_MODE: begin
                    nxt_cur.pulse_mode = pwdata[11:0];
                end
                ADDR_HALF_CYC: begin
                    nxt_cur.half_cyc = pwdata[15:0];
                end
                ADDR_LINE_CTRL: begin
                    nxt_cur.line_en = pwdata[0];
                end
                ADDR_PHASE_CAL: begin
                    nxt_cur.phase_cal = pwdata[9:0];
                end
                default: begin
                end
            endcase
        end

        // Bus answer: prepare in first access cycle, finish in the next
        if (bus_done) begin
            nxt_cur.ready = 1'b0;
            nxt_cur.err   = 1'b0;
            nxt_cur.rdata = 32'h0000_0000;
        end else if (acc_phase) begin
            nxt_cur.ready = 1'b1;
            nxt_cur.err   = !mapped;
            nxt_cur.rdata = pwrite ? 32'h0000_0000 : rd_mux;
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur_ff            <= '0;
            cur_ff.accumulation_mode_reg    <= RST_ACCUMULATION_MODE_REG;
            cur_ff.pulse_mode <= RST_PULSE_MODE;
            cur_ff.half_cyc   <= RST_HALF_CYC;
            cur_ff.phase_cal  <= RST_PHASE_CAL;
            cur_ff.pins       <= 3'h7;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    // ------------------------------------------------------------------
    // Outputs, all straight from the state register
    // ------------------------------------------------------------------
    assign prdata             = cur_ff.rdata;
    assign pready             = cur_ff.ready;
    assign pslverr            = cur_ff.err;
    assign pulse_out_first    = cur_ff.pins[0];
    assign pulse_out_second   = cur_ff.pins[1];
    assign pulse_out_third    = cur_ff.pins[2];
    assign pulse_power_select = cur_ff.pulse_mode[8:0];
    assign phase_cal          = cur_ff.phase_cal;

endmodule

// [bench/metering_event_status_sva.sv]
`timescale 1ns/1ps
// ------------------------------------------
// Port checks for the event status bank
// ------------------------------------------
module metering_event_status_chk
    import metering_pkg::*;
(
    input wire logic        pclk,           // Bus clock
    input wire logic        presetn,        // Reset, active low
    input wire logic        psel,           // APB select
    input wire logic        penable,        // APB access phase
    input wire logic        pwrite,         // APB write
    input wire logic [17:0] paddr,          // APB byte address
    input wire logic [31:0] prdata,         // APB read data
    input wire logic        pready,         // APB ready
    input wire logic        pslverr,        // APB error
    input wire logic [2:0]  pulse_level,    // Raw pulse levels
    input wire logic        pulse_out_first // Pulse pin 1
);
    // One clock domain, so clock and reset are given once
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // A read completes while ready is high; direction is still held
    wire rd_ok = pready && !pwrite;

    property p_ready_next; psel && penable && !pready |=> pready; endproperty
    a_ready_next: assert property (p_ready_next)
        else $error("ready missing after access phase");
    property p_ready_one; pready |=> !pready; endproperty
    a_ready_one: assert property (p_ready_one)
        else $error("ready held longer than one cycle");
    property p_idle_data; !pready |-> prdata == 32'h0 && !pslverr; endproperty
    a_idle_data: assert property (p_idle_data)
        else $error("read data or error outside a transfer");
    property p_peak_top; rd_ok && paddr == ADDR_PEAK |-> prdata[31:27] == 5'h00;
    endproperty
    a_peak_top: assert property (p_peak_top)
        else $error("peak register top bits not zero");
    property p_stat_top;
        rd_ok && paddr == ADDR_STATUS |-> prdata[31:19] == 13'h0000;
    endproperty
    a_stat_top: assert property (p_stat_top)
        else $error("status register top bits not zero");
    property p_mode_pad;
        rd_ok && paddr == ADDR_PULSE_MODE |-> prdata[31:20] == 12'h000;
    endproperty
    a_mode_pad: assert property (p_mode_pad)
        else $error("pulse mode read not zero padded");
    property p_smp_ext;
        rd_ok && paddr == ADDR_POWER_SMP |-> prdata[31:24] == {8{prdata[23]}};
    endproperty
    a_smp_ext: assert property (p_smp_ext)
        else $error("power sample read not sign extended");
    property p_cal_pad;
        rd_ok && paddr == ADDR_PHASE_CAL |-> prdata[31:10] == 22'h0;
    endproperty
    a_cal_pad: assert property (p_cal_pad)
        else $error("phase calibration read not zero padded");
    property p_pulse_low; !pulse_out_first |-> !$past(pulse_level[0]);
    endproperty
    a_pulse_low: assert property (p_pulse_low)
        else $error("pulse pin low without a low source");
endmodule

// [bench/tb.sv]
`timescale 1ns/1ps
module tb;
    import metering_pkg::*;
    // ------------------------------------------
    // Signals
    // ------------------------------------------
    logic        pclk        = 1'b0;
    logic        presetn     = 1'b0;
    logic        psel        = 1'b0;
    logic        penable     = 1'b0;
    logic        pwrite      = 1'b0;
    logic [17:0] paddr       = 18'h00000;
    logic [31:0] pwdata      = 32'h00000000;
    logic [2:0]  b30 [5]     = '{default: 3'h0};
    logic [2:0]  neg [5]     = '{default: 3'h0};
    logic [2:0]  pl          = 3'h7;
    logic        tick        = 1'b0;
    logic        dsp         = 1'b0;
    logic        pk_vld      = 1'b0;
    logic [23:0] pk_val      = 24'h000000;
    logic [2:0]  pk_ph       = 3'h0;
    logic [23:0] smp         = 24'h000000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        po1;
    logic        po2;
    logic        po3;
    logic [8:0]  pw_sel;
    logic [9:0]  cal;
    logic [31:0] r;
    logic        er;
    logic [31:0] m;
    int          bad_count   = 0;
    int          checks_done = 0;
    int          cyc         = 0;
    // Kind, index, status bit: 0-4 bit30, 5-9 signs, 10 pulse, 11 dsp
    int          rows [18][3] = '{'{0, 0, 0}, '{1, 1, 1}, '{2, 2, 2},
        '{3, 0, 3}, '{4, 1, 4}, '{5, 0, 6}, '{5, 1, 7}, '{5, 2, 8},
        '{7, 0, 10}, '{7, 1, 11}, '{7, 2, 12}, '{9, 0, 9}, '{9, 1, 13},
        '{9, 2, 18}, '{10, 0, 14}, '{10, 1, 15}, '{10, 2, 16}, '{11, 0, 17}};

    metering_event_status dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .tot_active_bit30(b30[0]),
        .fund_active_bit30(b30[1]), .tot_react_bit30(b30[2]),
        .fund_react_bit30(b30[3]), .apparent_bit30(b30[4]),
        .half_cycle_tick(tick), .tot_active_neg(neg[0]),
        .fund_active_neg(neg[1]), .tot_react_neg(neg[2]),
        .fund_react_neg(neg[3]), .path_sum_neg(neg[4]), .pulse_level(pl),
        .dsp_cycle_done(dsp), .peak_valid(pk_vld), .peak_value(pk_val),
        .peak_phase(pk_ph), .power_sample(smp), .pulse_out_first(po1),
        .pulse_out_second(po2), .pulse_out_third(po3),
        .pulse_power_select(pw_sel), .phase_cal(cal));

    // Clock at 200 MHz
    always #2.5 pclk = ~pclk;

    // Cycle ceiling cuts a hung handshake short
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            bad_count++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        if (bad_count == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask

    // One APB transfer; an idle edge follows so strobes never re-assert
    // in the time step that released them
    task automatic apb(input logic w, input logic [17:0] a,
                       input logic [31:0] d, output logic [31:0] rd_v,
                       output logic err);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // Only the bench ceiling ends this wait
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd_v = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rd(input logic [17:0] a, input logic [31:0] e,
                      input string nm);
        apb(1'b0, a, 32'h0, r, er);
        chk(nm, e, r);
    endtask

    task automatic wr(input logic [17:0] a, input logic [31:0] d);
        apb(1'b1, a, d, r, er);
    endtask

    // Flip one event input, or pulse the processing-done strobe
    task automatic poke(input int k, input int i);
        if (k < 5) b30[k][i] <= ~b30[k][i];
        else if (k < 10) neg[k-5][i] <= ~neg[k-5][i];
        else if (k == 10) pl[i] <= ~pl[i];
        else dsp <= 1'b1;
        @(posedge pclk);
        dsp <= 1'b0;
        pk_vld <= 1'b0;
        repeat (2) @(posedge pclk);
    endtask

    task automatic ticks(input int n);
        repeat (n) begin
            tick <= 1'b1;
            @(posedge pclk);
            tick <= 1'b0;
            @(posedge pclk);
        end
    endtask

    // Reset, single-event table, then the awkward cases
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(ADDR_STATUS, 32'h0, "status_rst");
        rd(ADDR_HALF_CYC, 32'hffff, "half_cyc_rst");
        wr(ADDR_PEAK, 32'hffffffff);
        rd(ADDR_PEAK, 32'h0, "peak_ro");
        apb(1'b0, 18'h00010, 32'h0, r, er);
        chk("unmapped_err", 32'h1, {31'h0, er});
        pk_val <= 24'h9abcde;
        pk_ph <= 3'b010;
        pk_vld <= 1'b1;
        smp <= 24'h800123;
        poke(11, 0);
        rd(ADDR_PEAK, 32'h029abcde, "peak");
        rd(ADDR_POWER_SMP, 32'hff800123, "sample");
        wr(ADDR_STATUS, 32'hffffffff);
        for (int n = 0; n < 18; n++) begin
            m = 32'h1 << rows[n][2];
            poke(rows[n][0], rows[n][1]);
            rd(ADDR_STATUS, m, "status_set");
            wr(ADDR_STATUS, 32'h0);
            rd(ADDR_STATUS, m, "status_kept");
            wr(ADDR_STATUS, m);
            rd(ADDR_STATUS, 32'h0, "status_clr");
        end
        rd(ADDR_SIGN, 32'h1ff, "signs");
        wr(ADDR_ACCUMULATION_MODE_REG, 32'h40);
        rd(ADDR_STATUS, 32'h1c0, "sel_flag");
        rd(ADDR_SIGN, 32'h1f8, "sel_sign");
        wr(ADDR_PULSE_MODE, 32'hffffffff);
        rd(ADDR_PULSE_MODE, 32'hfff, "pmode");
        chk("pw_sel", 32'h1ff, {23'h0, pw_sel});
        wr(ADDR_STATUS, 32'hffffffff);
        poke(10, 0);
        poke(10, 0);
        rd(ADDR_STATUS, 32'h4000, "dis_flag");
        chk("dis_pin", 32'h1, {31'h0, po1});
        chk("dis_pin3", 32'h1, {31'h0, po3});
        wr(ADDR_PULSE_MODE, 32'h0);
        // Pins follow the mode one edge after the write lands
        @(posedge pclk);
        chk("pin2", 32'h0, {31'h0, po2});
        chk("pin3", 32'h0, {31'h0, po3});
        wr(ADDR_PHASE_CAL, 32'hffffffff);
        rd(ADDR_PHASE_CAL, 32'h3ff, "cal");
        chk("cal_out", 32'h3ff, {22'h0, cal});
        wr(ADDR_STATUS, 32'hffffffff);
        wr(ADDR_HALF_CYC, 32'h3);
        wr(ADDR_LINE_CTRL, 32'h1);
        ticks(2);
        rd(ADDR_STATUS, 32'h0, "line_early");
        ticks(1);
        rd(ADDR_STATUS, 32'h20, "line_done");
        // Mid-run reset with a flag pending and event inputs not at zero
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(ADDR_STATUS, 32'h0, "status_rst2");
        rd(ADDR_PEAK, 32'h0, "peak_rst2");
        give_verdict();
    end
endmodule

bind metering_event_status metering_event_status_chk chk (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
    .pslverr, .pulse_level, .pulse_out_first);
